// ===== rtl/asw_host.sv
`timescale 1ns/1ns
module asw_host
  import asw_pkg::*;
#(
  parameter int RST_CYC = RESET_LOW_CYC,
  parameter int PRS_CYC = PRESENCE_SAMPLE_CYC,
  parameter int REC_CYC = RECOVERY_CYC,
  // Slot timing; a bench may shorten it together with its partner model
  parameter int SLT_CYC = SLOT_CYC,
  parameter int W0_CYC = WR0_LOW_CYC,
  parameter int ST_CYC = START_LOW_CYC,
  parameter int RS_CYC = READ_SAMPLE_CYC
) (
  input wire logic I_SYS_CLK,
  input wire logic I_NRST,
  input wire logic i_start,
  input wire logic [1:0] i_op,
  input wire logic [63:0] i_id,
  input wire logic i_line,
  output logic o_line_oe,
  output logic o_busy,
  output logic o_done,
  output logic o_presence,
  output logic [63:0] o_id,
  output logic o_sense,
  output logic o_search_last,
  output logic o_search_fail
);
  // ==========================================
  // Controller states
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_RST = 7'b0000010,
    ST_CMD = 7'b0000100,
    ST_IDRD = 7'b0001000,
    ST_IDWR = 7'b0010000,
    ST_SRCH = 7'b0100000,
    ST_SNS = 7'b1000000
  } asw_state_t;

  asw_slot_if sif ();
  asw_state_t st_q;
  logic [1:0] op_q;
  logic [7:0] cmd_q;
  logic [63:0] id_q, wid_q;
  logic [5:0] bit_q;
  logic [2:0] cbit_q;
  logic [1:0] ph_q;
  logic b0_q;
  logic [6:0] last_q, mark_q;
  logic go_q, krst_q, wb_q, busy_q, done_q, pres_q, sns_q, slast_q, sfail_q;
  logic slot_ok, pair_none, pair_conf, take_one;
  logic [6:0] bitpos;

  asw_slot #(
    .RST_CYC(RST_CYC),
    .PRS_CYC(PRS_CYC),
    .REC_CYC(REC_CYC),
    .SLT_CYC(SLT_CYC),
    .W0_CYC(W0_CYC),
    .ST_CYC(ST_CYC),
    .RS_CYC(RS_CYC)
  ) u_slot (
    .i_clk(I_SYS_CLK),
    .i_nrst(I_NRST),
    .sif(sif),
    .i_line(i_line),
    .o_line_oe(o_line_oe)
  );

  assign sif.go = go_q;
  assign sif.kind_rst = krst_q;
  assign sif.wbit = wb_q;
  assign slot_ok = sif.done && !go_q;

  // ==========================================
  // Search decision on the bit / complement pair
  assign bitpos = {1'b0, bit_q} + 7'h01;
  assign pair_none = b0_q && sif.rbit;
  assign pair_conf = !b0_q && !sif.rbit;
  // Conflict: repeat old path below the last mark, take 1 at it, 0 above
  assign take_one = pair_conf ? ((bitpos < last_q) ? id_q[bit_q] : (bitpos == last_q))
                              : b0_q;

  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      st_q <= ST_IDLE;
      op_q <= OP_READ_ID;
      cmd_q <= 8'h00;
      id_q <= 64'h0000000000000000;
      wid_q <= 64'h0000000000000000;
      bit_q <= 6'h00;
      cbit_q <= 3'h0;
      ph_q <= 2'h0;
      b0_q <= 1'b1;
      last_q <= 7'h00;
      mark_q <= 7'h00;
      go_q <= 1'b0;
      krst_q <= 1'b0;
      wb_q <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      pres_q <= 1'b0;
      sns_q <= 1'b1;
      slast_q <= 1'b1;
      sfail_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      done_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          if (i_start) begin
            op_q <= i_op;
            wid_q <= i_id;
            busy_q <= 1'b1;
            if (i_op == OP_SENSE) begin
              // Sense only after a select or search; no new reset
              wb_q <= 1'b1;
              go_q <= 1'b1;
              st_q <= ST_SNS;
            end else begin
              krst_q <= 1'b1;
              go_q <= 1'b1;
              if (i_op == OP_SEARCH && slast_q) begin
                last_q <= 7'h00;
              end
              st_q <= ST_RST;
            end
          end
        end
        ST_RST: begin
          if (slot_ok) begin
            pres_q <= sif.rbit;
            krst_q <= 1'b0;
            if (!sif.rbit) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              st_q <= ST_IDLE;
            end else begin
              // Only the three known codes ever go out
              cmd_q <= (op_q == OP_SELECT) ? CMD_SELECT
                     : (op_q == OP_SEARCH) ? CMD_SEARCH : CMD_READ_ID;
              wb_q <= (op_q == OP_SELECT) ? CMD_SELECT[0]
                    : (op_q == OP_SEARCH) ? CMD_SEARCH[0] : CMD_READ_ID[0];
              cbit_q <= 3'h0;
              go_q <= 1'b1;
              mark_q <= 7'h00;
              st_q <= ST_CMD;
            end
          end
        end
        ST_CMD: begin
          if (slot_ok) begin
            bit_q <= 6'h00;
            ph_q <= 2'h0;
            go_q <= 1'b1;
            if (cbit_q == 3'(CMD_BITS - 1)) begin
              if (op_q == OP_SELECT) begin
                wb_q <= wid_q[0];
                st_q <= ST_IDWR;
              end else begin
                wb_q <= 1'b1;
                st_q <= (op_q == OP_SEARCH) ? ST_SRCH : ST_IDRD;
              end
            end else begin
              cbit_q <= cbit_q + 3'h1;
              wb_q <= cmd_q[cbit_q + 3'h1];
            end
          end
        end
        ST_IDRD: begin
          if (slot_ok) begin
            id_q[bit_q] <= sif.rbit;
            if (bit_q == 6'(ID_BITS - 1)) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              st_q <= ST_IDLE;
            end else begin
              bit_q <= bit_q + 6'h01;
              go_q <= 1'b1;
            end
          end
        end
        ST_IDWR: begin
          if (slot_ok) begin
            if (bit_q == 6'(ID_BITS - 1)) begin
              id_q <= wid_q;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              st_q <= ST_IDLE;
            end else begin
              bit_q <= bit_q + 6'h01;
              wb_q <= wid_q[bit_q + 6'h01];
              go_q <= 1'b1;
            end
          end
        end
        ST_SRCH: begin
          if (slot_ok) begin
            go_q <= 1'b1;
            unique case (ph_q)
              2'h0: begin
                b0_q <= sif.rbit;
                wb_q <= 1'b1;
                ph_q <= 2'h1;
              end
              2'h1: begin
                if (pair_none) begin
                  go_q <= 1'b0;
                  sfail_q <= 1'b1;
                  slast_q <= 1'b1;
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                  st_q <= ST_IDLE;
                end else begin
                  if (pair_conf && !take_one) begin
                    mark_q <= bitpos;
                  end
                  id_q[bit_q] <= take_one;
                  wb_q <= take_one;
                  ph_q <= 2'h2;
                end
              end
              default: begin
                ph_q <= 2'h0;
                wb_q <= 1'b1;
                if (bit_q == 6'(ID_BITS - 1)) begin
                  // Found slave keeps its switch; no toggle here
                  go_q <= 1'b0;
                  last_q <= mark_q;
                  slast_q <= (mark_q == 7'h00);
                  sfail_q <= 1'b0;
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                  st_q <= ST_IDLE;
                end else begin
                  bit_q <= bit_q + 6'h01;
                end
              end
            endcase
          end
        end
        ST_SNS: begin
          if (slot_ok) begin
            sns_q <= sif.rbit;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_presence = pres_q;
  assign o_id = id_q;
  assign o_sense = sns_q;
  assign o_search_last = slast_q;
  assign o_search_fail = sfail_q;
endmodule

// ===== rtl/asw_pkg.sv
package asw_pkg;
  // Bus timing, in microseconds as printed, and cycle counts at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int RESET_LOW_TIME_US = 480;
  localparam int RESET_LOW_CYC = RESET_LOW_TIME_US * CLK_MHZ;
  // Presence sample point: after the longest wait, inside the shortest pulse
  localparam int PRESENCE_WAIT_MAX_US = 60;
  localparam int PRESENCE_LOW_MIN_US = 60;
  localparam int PRESENCE_SAMPLE_US = PRESENCE_WAIT_MAX_US + PRESENCE_LOW_MIN_US / 2;
  localparam int PRESENCE_SAMPLE_CYC = PRESENCE_SAMPLE_US * CLK_MHZ;
  localparam int PRESENCE_WAIT_TIME_US = 15;
  localparam int PRESENCE_LOW_TIME_US = 240;
  localparam int RECOVERY_US = PRESENCE_WAIT_MAX_US + PRESENCE_LOW_TIME_US;
  localparam int RECOVERY_CYC = RECOVERY_US * CLK_MHZ;
  // Slot timing; writes and holds stay well under the 120 us line-low limit
  localparam int SLOT_US = 70;
  localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
  localparam int WR0_LOW_US = 60;
  localparam int WR0_LOW_CYC = WR0_LOW_US * CLK_MHZ;
  localparam int START_LOW_US = 2;
  localparam int START_LOW_CYC = START_LOW_US * CLK_MHZ;
  localparam int READ_SAMPLE_US = 12;
  localparam int READ_SAMPLE_CYC = READ_SAMPLE_US * CLK_MHZ;
  localparam int LINE_LOW_LIMIT_US = 120;
  // Command codes
  localparam logic [7:0] CMD_READ_ID = 8'h33;
  localparam logic [7:0] CMD_SELECT = 8'h55;
  localparam logic [7:0] CMD_SEARCH = 8'hF0;
  localparam int ID_BITS = 64;
  localparam int CMD_BITS = 8;
  // Host operations
  localparam logic [1:0] OP_READ_ID = 2'h0;
  localparam logic [1:0] OP_SELECT = 2'h1;
  localparam logic [1:0] OP_SEARCH = 2'h2;
  localparam logic [1:0] OP_SENSE = 2'h3;
  typedef enum logic [2:0] {
    SL_IDLE = 3'b001,
    SL_LOW = 3'b010,
    SL_REL = 3'b100
  } asw_slot_t;
endpackage

// ===== rtl/asw_slot_if.sv
`timescale 1ns/1ns
interface asw_slot_if;
  logic go;
  logic kind_rst;
  logic wbit;
  logic busy;
  logic done;
  logic rbit;
  modport ctl (output go, kind_rst, wbit, input busy, done, rbit);
  modport eng (input go, kind_rst, wbit, output busy, done, rbit);
endinterface

// ===== rtl/asw_slot.sv
`timescale 1ns/1ns
module asw_slot
  import asw_pkg::*;
#(
  parameter int RST_CYC = RESET_LOW_CYC,
  parameter int PRS_CYC = PRESENCE_SAMPLE_CYC,
  parameter int REC_CYC = RECOVERY_CYC,
  parameter int SLT_CYC = SLOT_CYC,
  parameter int W0_CYC = WR0_LOW_CYC,
  parameter int ST_CYC = START_LOW_CYC,
  parameter int RS_CYC = READ_SAMPLE_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  asw_slot_if.eng sif,
  input wire logic i_line,
  output logic o_line_oe
);
  // ==========================================
  // Slot engine: one reset or one bit slot per go
  asw_slot_t st_q;
  logic [16:0] cnt_q;
  logic rst_q, w_q, oe_q, rb_q, done_q;
  logic [16:0] low_len, smp_at, end_at;

  // Low length: reset pulse, write 0 / short start for write 1 and read
  assign low_len = rst_q ? 17'(RST_CYC) : (w_q ? 17'(ST_CYC) : 17'(W0_CYC));
  assign smp_at = rst_q ? 17'(PRS_CYC) : 17'(RS_CYC);
  assign end_at = rst_q ? 17'(REC_CYC) : 17'(SLT_CYC - W0_CYC);

  // Sequencer; cnt restarts at release only for a reset, so bit-slot samples are timed from the fall
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= SL_IDLE;
      cnt_q <= 17'h00000;
      rst_q <= 1'b0;
      w_q <= 1'b1;
      oe_q <= 1'b0;
      rb_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        SL_IDLE: begin
          if (sif.go) begin
            rst_q <= sif.kind_rst;
            w_q <= sif.wbit;
            oe_q <= 1'b1;
            cnt_q <= 17'h00000;
            st_q <= SL_LOW;
          end
        end
        SL_LOW: begin
          cnt_q <= cnt_q + 17'h00001;
          if (cnt_q == low_len - 17'h00001) begin
            oe_q <= 1'b0;
            cnt_q <= rst_q ? 17'h00000 : low_len;
            st_q <= SL_REL;
          end
        end
        SL_REL: begin
          cnt_q <= cnt_q + 17'h00001;
          // Read sample: low means a responder pulled it, the wired AND
          if (cnt_q == smp_at) begin
            rb_q <= rst_q ? !i_line : i_line;
          end
          if (cnt_q >= (rst_q ? end_at : 17'(SLT_CYC))) begin
            done_q <= 1'b1;
            st_q <= SL_IDLE;
          end
        end
        default: st_q <= SL_IDLE;
      endcase
    end
  end

  assign o_line_oe = oe_q;
  assign sif.busy = (st_q != SL_IDLE);
  assign sif.done = done_q;
  assign sif.rbit = rb_q;
endmodule

// ===== verif/asw_host_properties.sv
`timescale 1ns/1ns
// ==========
// Line and handshake checks on the host ports
module asw_host_properties
  import asw_pkg::*;
#(
  parameter int RST_CYC = RESET_LOW_CYC,
  parameter int PRS_CYC = PRESENCE_SAMPLE_CYC,
  parameter int REC_CYC = RECOVERY_CYC,
  parameter int SLT_CYC = SLOT_CYC,
  parameter int W0_CYC = WR0_LOW_CYC
) (
  input wire logic I_SYS_CLK,
  input wire logic I_NRST,
  input wire logic i_start,
  input wire logic [1:0] i_op,
  input wire logic [63:0] i_id,
  input wire logic i_line,
  input wire logic o_line_oe,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_presence,
  input wire logic [63:0] o_id,
  input wire logic o_sense,
  input wire logic o_search_last,
  input wire logic o_search_fail
);
  int high_q;
  int low_q;
  int high_d;
  int low_d;
  // Drive and release lengths; release saturates so a long idle never wraps
  assign high_d = o_line_oe ? high_q + 1 : 0;
  assign low_d = o_line_oe ? 0 : (low_q < 100000 ? low_q + 1 : low_q);
  // Idle counts as a long release, so the first reset pulse is legal
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      high_q <= 0;
      low_q <= 100000;
    end else begin
      high_q <= high_d;
      low_q <= low_d;
    end
  end
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_NRST);
  a_start_taken: assert property (i_start && !o_busy |=> o_busy)
    else $error("accepted start did not raise busy");
  a_busy_cause: assert property ($rose(o_busy) |-> $past(i_start) && !$past(o_busy))
    else $error("busy rose without an accepted start");
  a_done_single: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_done_released: assert property (o_done |-> !o_line_oe)
    else $error("line still driven at done");
  a_idle_release: assert property (!o_busy |-> !o_line_oe)
    else $error("line driven while idle");
  a_first_pulse: assert property ($rose(o_busy) |=> o_line_oe [*8])
    else $error("operation did not open with a low pulse");
  a_reset_width: assert property ($fell(o_line_oe) && high_q > W0_CYC + 2 |->
    high_q >= RST_CYC && high_q <= RST_CYC + 2) else $error("reset pulse width wrong");
  a_slot_width: assert property ($fell(o_line_oe) && high_q < RST_CYC |->
    high_q <= W0_CYC + 2) else $error("slot low time too long");
  // Shortest release is the tail of a write-zero slot
  a_slot_gap: assert property ($rose(o_line_oe) |-> low_q >= SLT_CYC - W0_CYC)
    else $error("slot recovery too short");
  a_results_hold: assert property (!o_busy && !i_start |=>
    $stable(o_id) && $stable(o_sense) && $stable(o_presence)) else $error("result moved idle");
endmodule

// ===== verif/asw_dev_model.sv
`timescale 1ns/1ns
// ==========
// Behavioural addressable switch on the open-drain line
module asw_dev_model #(
  parameter logic [63:0] DEV_ID = 64'h0
) (
  input wire logic i_clk,
  input wire logic i_line,
  input wire logic i_en,
  output logic o_pull,
  output logic o_sw
);
  // Scaled to the bench's shortened slots: hold past the host sample point
  localparam int HOLD0_CYC = 15;
  localparam int SAMPLE_CYC = 30;
  localparam int RST_DET_CYC = 120;
  logic pull_q;
  // Detached device never touches the line
  assign o_pull = pull_q & i_en;
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Only a low longer than any slot counts as reset
  task automatic det_reset();
    int cnt;
    cnt = 0;
    while (cnt <= RST_DET_CYC) begin
      @(posedge i_clk);
      cnt = (i_line === 1'h0) ? cnt + 1 : 0;
    end
  endtask
  // One slot timed from the falling edge: hold a zero, then sample
  task automatic slot(input logic tx, output logic rx);
    @(negedge i_line);
    if (!tx) pull_q <= 1'h1;
    tick(HOLD0_CYC);
    pull_q <= 1'h0;
    tick(SAMPLE_CYC - HOLD0_CYC);
    rx = i_line;
  endtask
  task automatic txn();
    logic [7:0] cmd;
    logic b;
    logic sel;
    for (int i = 0; i < 8; i++) begin
      slot(1'h1, b);
      cmd[i] = b;
    end
    sel = 1'h0;
    case (cmd)
      8'h33: for (int i = 0; i < 64; i++) slot(DEV_ID[i], b);
      8'h55: begin
        sel = 1'h1;
        for (int i = 0; i < 64; i++) begin
          slot(1'h1, b);
          if (b !== DEV_ID[i]) sel = 1'h0;
        end
        if (sel) o_sw = ~o_sw;
      end
      8'hF0: begin
        sel = 1'h1;
        for (int i = 0; i < 64; i++) begin
          slot(DEV_ID[i], b);
          slot(~DEV_ID[i], b);
          slot(1'h1, b);
          if (b !== DEV_ID[i]) begin
            sel = 1'h0;
            break;
          end
        end
      end
      default: sel = 1'h0;
    endcase
    // Selected: report pin level, low while the pulldown is on
    if (sel) forever slot(~o_sw, b);
    forever @(posedge i_clk);
  endtask
  // Reset, presence, then one command until the next reset
  initial begin
    pull_q = 1'h0;
    o_sw = 1'h0;
    det_reset();
    forever begin
      pull_q <= 1'h0;
      @(posedge i_line);
      tick(20);
      pull_q <= 1'h1;
      tick(100);
      pull_q <= 1'h0;
      fork
        txn();
        det_reset();
      join_any
      disable fork;
    end
  end
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ns
// ==========
// Host against two switch models
module testbench;
  import asw_pkg::*;
  // Timing shortened so the whole run stays well under 100k cycles
  localparam int T_RST = 480;
  localparam int T_PRS = 90;
  localparam int T_REC = 300;
  localparam int T_SLT = 70;
  localparam int T_W0 = 60;
  localparam int T_ST = 10;
  localparam int T_RS = 12;
  // Identity values are arbitrary; they differ first at bit 8
  localparam logic [63:0] ID_A = 64'h5A00_0000_1234_563C;
  localparam logic [63:0] ID_B = 64'h5A00_0000_1234_573C;
  logic sys_clk, nrst, start, en_a, en_b;
  logic [1:0] op;
  logic [63:0] id_in, id_out;
  logic line_oe, pull_a, pull_b, sw_a, sw_b, busy, done, presence, sense, s_last, s_fail;
  wire line;
  int err_count, cmp_count;
  // Pull-up line: any party pulling wins
  assign line = ~(line_oe | pull_a | pull_b);
  asw_host #(.RST_CYC(T_RST), .PRS_CYC(T_PRS), .REC_CYC(T_REC), .SLT_CYC(T_SLT),
    .W0_CYC(T_W0), .ST_CYC(T_ST), .RS_CYC(T_RS)) i_dut (
    .I_SYS_CLK(sys_clk), .I_NRST(nrst), .i_start(start), .i_op(op), .i_id(id_in),
    .i_line(line), .o_line_oe(line_oe), .o_busy(busy), .o_done(done),
    .o_presence(presence), .o_id(id_out), .o_sense(sense), .o_search_last(s_last),
    .o_search_fail(s_fail));
  asw_dev_model #(.DEV_ID(ID_A)) i_dev_a (.i_clk(sys_clk), .i_line(line), .i_en(en_a),
    .o_pull(pull_a), .o_sw(sw_a));
  asw_dev_model #(.DEV_ID(ID_B)) i_dev_b (.i_clk(sys_clk), .i_line(line), .i_en(en_b),
    .o_pull(pull_b), .o_sw(sw_b));
  task automatic wrap_up();
    if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Start on a falling edge, then wait for done under a bound
  task automatic run_op(input logic [1:0] o, input logic [63:0] d);
    int n;
    @(negedge sys_clk);
    start = 1'h1;
    op = o;
    id_in = d;
    @(negedge sys_clk);
    start = 1'h0;
    n = 0;
    while (done !== 1'h1) begin
      @(negedge sys_clk);
      n++;
      if (n > 25000) begin
        err_count++;
        $display("[ERR] done expected 1 seen timeout");
        wrap_up();
      end
    end
  endtask
  task automatic t_no_presence();
    run_op(OP_READ_ID, 64'h0);
    check("presence", 64'(presence), 64'h0);
  endtask
  task automatic t_read_id();
    en_a = 1'h1;
    run_op(OP_READ_ID, 64'h0);
    check("presence", 64'(presence), 64'h1);
    check("read id", id_out, ID_A);
  endtask
  task automatic t_select();
    en_b = 1'h1;
    run_op(OP_SELECT, ID_B);
    check("switch b", 64'(sw_b), 64'h1);
    check("switch a", 64'(sw_a), 64'h0);
    run_op(OP_SENSE, 64'h0);
    check("sense b", 64'(sense), 64'h0);
  endtask
  task automatic t_search();
    run_op(OP_SEARCH, 64'h0);
    check("search id 1", id_out, ID_A);
    check("search last 1", 64'(s_last), 64'h0);
    check("search fail", 64'(s_fail), 64'h0);
    check("switch kept", 64'({sw_a, sw_b}), 64'h1);
    run_op(OP_SENSE, 64'h0);
    check("sense a", 64'(sense), 64'h1);
    run_op(OP_SEARCH, 64'h0);
    check("search id 2", id_out, ID_B);
    check("search last 2", 64'(s_last), 64'h1);
  endtask
  // Free-running 100 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Reset, then the scenarios in order
  initial begin
    nrst = 1'h0;
    start = 1'h0;
    op = OP_READ_ID;
    id_in = 64'h0;
    en_a = 1'h0;
    en_b = 1'h0;
    err_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'h1;
    t_no_presence();
    t_read_id();
    t_select();
    t_search();
    wrap_up();
  end
endmodule
bind asw_host asw_host_properties #(.RST_CYC(RST_CYC), .PRS_CYC(PRS_CYC), .REC_CYC(REC_CYC),
  .SLT_CYC(SLT_CYC), .W0_CYC(W0_CYC))
  i_props (.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST), .i_start(i_start), .i_op(i_op),
  .i_id(i_id), .i_line(i_line), .o_line_oe(o_line_oe), .o_busy(o_busy), .o_done(o_done),
  .o_presence(o_presence), .o_id(o_id), .o_sense(o_sense), .o_search_last(o_search_last),
  .o_search_fail(o_search_fail));
